// [rcause_pkg.sv]
// Package with register map, field positions and reset values
// ***********************************************************
// What this block does
// R1 - Sleep instruction sets sleep-wake flag bit 3
// R2 - Idle instruction sets idle-wake flag bit 2
// R3 - Brown-out or power-on sets brown-out flag bit 1
// R4 - Power-up sets power-on flag bit 0
// R5 - Software sets or clears flags, no reset
// R6 - Trap, opcode, mismatch, clear, software flags set
// R7 - Sleep with deep enable sets deep flag
// R8 - Fuse at one forces watchdog always enabled
// R9 - Deep enable picks deep or ordinary sleep
// R10 - Deep brown-out bit only on detected event
// R11 - Pin-hold keeps pins; hardware sets, software clears
// R12 - Clearing pin-hold returns pins to port registers
// R13 - Deep control resets only on outside power-on
// R14 - Deep-sleep brown-out rearms power-on, no wake
// R15 - Deep control bits 14..2 read zero
// R16 - Hardware set beats software write
// ***********************************************************
package rcause_pkg;
    // Register byte addresses
    localparam logic [11:0] ADDR_FLAGS   = 12'h000;
    localparam logic [11:0] ADDR_DSCTRL  = 12'h004;
    localparam logic [11:0] ADDR_WDT     = 12'h008;
    // Flag bit positions
    localparam int B_TRAP   = 15;
    localparam int B_ILLOP  = 14;
    localparam int B_DEEP   = 10;
    localparam int B_CFGMM  = 9;
    localparam int B_EXTERNAL_RESET_FLAG   = 7;
    localparam int B_SWR    = 6;
    localparam int B_WATCHDOG_TIMEOUT_FLAG   = 4;
    localparam int B_SLEEP  = 3;
    localparam int B_IDLE   = 2;
    localparam int B_BOR    = 1;
    localparam int B_POR    = 0;
    // Deep control bit positions
    localparam int B_DSEN   = 15;
    localparam int B_DEEP_SLEEP_BROWNOUT_FLAG  = 1;
    localparam int B_HOLD   = 0;
    // Implemented masks and reset values
    localparam logic [15:0] FLAGS_MASK  = 16'hc6df;
    localparam logic [15:0] FLAGS_POR   = 16'h0003;
    localparam logic [15:0] DSCTRL_MASK = 16'h8003;
    localparam logic [15:0] DSCTRL_RST  = 16'h0000;
    // Pin count default
    localparam int PIN_COUNT = 24;
endpackage

// [pin_hold_latch.sv]
// Pin state hold latch for deep-sleep wake-up
`timescale 1ns/1ns
`default_nettype none
module pin_hold_latch #(
    parameter int N = 24
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         capture,
    input  wire logic         hold,
    input  wire logic [N-1:0] dir_in,
    input  wire logic [N-1:0] lat_in,
    output logic      [N-1:0] dir_out,
    output logic      [N-1:0] lat_out
);
    logic [N-1:0] dir_save_reg;  // Direction before entry
    logic [N-1:0] lat_save_reg;  // Level before entry

    // Snapshot port state on deep-sleep entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_save_reg <= '1;
            lat_save_reg <= '0;
        end else if (capture) begin
            dir_save_reg <= dir_in;
            lat_save_reg <= lat_in;
        end
    end

    // Drive held state or live port registers, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_out <= '1;
            lat_out <= '0;
        end else if (hold) begin
            dir_out <= dir_save_reg;  // R11
            lat_out <= lat_save_reg;
        end else begin
            dir_out <= dir_in;  // R12
            lat_out <= lat_in;
        end
    end
endmodule
`default_nettype wire

// [reset_cause_deep_sleep_ctrl.sv]
// Reset cause flags and deep-sleep control with APB slave
`timescale 1ns/1ns
`default_nettype none
module reset_cause_deep_sleep_ctrl
    import rcause_pkg::*;
#(
    parameter int N_PINS = PIN_COUNT
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              por_event,
    input  wire logic              bor_event,
    input  wire logic              ext_reset_event,
    input  wire logic              sw_reset_event,
    input  wire logic              wdt_timeout_event,
    input  wire logic              trap_conflict_event,
    input  wire logic              illegal_op_event,
    input  wire logic              config_mismatch_event,
    input  wire logic              power_save_instruction_sleep,
    input  wire logic              power_save_instruction_idle,
    input  wire logic              ds_bor_enable,
    input  wire logic              ds_wake,
    input  wire logic              watchdog_fuse_enable,
    input  wire logic [N_PINS-1:0] port_direction_register,
    input  wire logic [N_PINS-1:0] port_latch_register,
    output logic      [N_PINS-1:0] pin_direction,
    output logic      [N_PINS-1:0] pin_level,
    output logic                   watchdog_enable,
    output logic                   deep_sleep_active,
    output logic                   sleep_active,
    output logic                   idle_active,
    output logic                   por_rearm
);
    // ***********************************************************
    // Declarations
    // ***********************************************************
    typedef enum logic [1:0] {
        PS_RUN,
        PS_IDLE,
        PS_SLEEP,
        PS_DEEP
    } pstate_t;

    pstate_t     state_reg;        // Power state
    pstate_t     state_next;       // Next power state
    logic [15:0] flags_reg;        // Reset cause flags
    logic [15:0] flags_next;       // Next flags
    logic [15:0] set_vec;          // Hardware set requests
    logic [15:0] clr_vec;          // Hardware clear requests
    logic        dsen_reg;         // Deep sleep enable
    logic        deep_sleep_brownout_flag_reg;        // Deep-sleep brown-out seen
    logic        hold_reg;         // Pin hold
    logic        soft_wdt_reg;     // Software watchdog enable
    logic        wr_en;            // Write in access phase
    logic        rd_en;            // Read in access phase
    logic        hit_flags;        // Flags address decoded
    logic        hit_ds;           // Deep control decoded
    logic        hit_wdt;          // Watchdog control decoded
    logic        deep_entry;       // Entering deep sleep
    logic        outside_por;      // Power-on not in deep sleep
    logic [15:0] ds_view;          // Deep control read value

    // Merge a 16-bit write under byte strobes
    function automatic logic [15:0] merge16(
        input logic [15:0] old_v,
        input logic [31:0] wd,
        input logic [3:0]  st
    );
        logic [15:0] r;
        r = old_v;
        if (st[0]) begin
            r[7:0] = wd[7:0];
        end
        if (st[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    // ***********************************************************
    // Bus decode
    // ***********************************************************
    // Zero wait states: every access completes in its access phase
    assign wr_en     = psel & penable & pwrite;
    assign rd_en     = psel & penable & ~pwrite;
    assign hit_flags = (paddr == ADDR_FLAGS);
    assign hit_ds    = (paddr == ADDR_DSCTRL);
    assign hit_wdt   = (paddr == ADDR_WDT);
    assign deep_entry = power_save_instruction_sleep & dsen_reg;  // R9
    // Power-on seen while in deep sleep wakes to run, keeps control
    assign outside_por = por_event & (state_reg != PS_DEEP);  // R13
    assign ds_view = {dsen_reg, 13'h0000, deep_sleep_brownout_flag_reg, hold_reg};  // R15

    // ***********************************************************
    // Reset cause flags
    // ***********************************************************
    // Hardware set and clear requests
    always_comb begin
        set_vec = 16'h0000;
        clr_vec = 16'h0000;
        set_vec[B_TRAP]  = trap_conflict_event;  // R6
        set_vec[B_ILLOP] = illegal_op_event;  // R6
        set_vec[B_CFGMM] = config_mismatch_event;  // R6
        set_vec[B_EXTERNAL_RESET_FLAG]  = ext_reset_event;  // R6
        set_vec[B_SWR]   = sw_reset_event;  // R6
        set_vec[B_WATCHDOG_TIMEOUT_FLAG]  = wdt_timeout_event;
        set_vec[B_DEEP]  = deep_entry;  // R7
        set_vec[B_SLEEP] = power_save_instruction_sleep;  // R1
        set_vec[B_IDLE]  = power_save_instruction_idle;  // R2
        set_vec[B_BOR]   = bor_event | por_event;  // R3
        set_vec[B_POR]   = por_event;  // R4
        // Timeout flag cleared by any power-save instruction
        clr_vec[B_WATCHDOG_TIMEOUT_FLAG]  = power_save_instruction_sleep | power_save_instruction_idle;
    end

    // Next flags: clear, software write, then hardware set wins
    always_comb begin
        flags_next = flags_reg;
        // Power-on wipes every cause; the set vector restores bits 1,0
        if (por_event) begin
            flags_next = 16'h0000;
        end
        flags_next = flags_next & ~clr_vec;
        if (wr_en && hit_flags) begin
            flags_next = merge16(flags_next, pwdata, pstrb);  // R5
        end
        flags_next = (flags_next | set_vec) & FLAGS_MASK;  // R16
    end

    // Flags register; a software write never triggers a reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= FLAGS_POR;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ***********************************************************
    // Deep sleep control
    // ***********************************************************
    // Enable bit, writable; reset only by outside power-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dsen_reg <= DSCTRL_RST[B_DSEN];
        end else if (outside_por) begin
            dsen_reg <= DSCTRL_RST[B_DSEN];  // R13
        end else if (wr_en && hit_ds && pstrb[1]) begin
            dsen_reg <= pwdata[B_DSEN];
        end
    end

    // Brown-out during deep sleep, only when detection active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deep_sleep_brownout_flag_reg <= DSCTRL_RST[B_DEEP_SLEEP_BROWNOUT_FLAG];
        end else if (state_reg == PS_DEEP && ds_bor_enable
                     && bor_event) begin
            deep_sleep_brownout_flag_reg <= 1'b1;  // R10
        end else if (outside_por) begin
            deep_sleep_brownout_flag_reg <= DSCTRL_RST[B_DEEP_SLEEP_BROWNOUT_FLAG];  // R13
        end else if (wr_en && hit_ds && pstrb[0]) begin
            deep_sleep_brownout_flag_reg <= pwdata[B_DEEP_SLEEP_BROWNOUT_FLAG];
        end
    end

    // Pin hold: set by hardware on deep entry, software clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg <= DSCTRL_RST[B_HOLD];
        end else if (deep_entry && state_reg == PS_RUN) begin
            hold_reg <= 1'b1;  // R11
        end else if (outside_por) begin
            hold_reg <= DSCTRL_RST[B_HOLD];  // R13
        end else if (wr_en && hit_ds && pstrb[0]
                     && !pwdata[B_HOLD]) begin
            hold_reg <= 1'b0;  // R12
        end
    end

    // ***********************************************************
    // Power state
    // ***********************************************************
    // Next power state from instructions and wake
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PS_RUN: begin
                if (deep_entry) begin
                    state_next = PS_DEEP;  // R9
                end else if (power_save_instruction_sleep) begin
                    state_next = PS_SLEEP;  // R9
                end else if (power_save_instruction_idle) begin
                    state_next = PS_IDLE;
                end
            end
            PS_IDLE, PS_SLEEP: begin
                if (ds_wake || por_event || bor_event) begin
                    state_next = PS_RUN;
                end
            end
            PS_DEEP: begin
                // Brown-out does not wake deep sleep
                if (ds_wake || por_event) begin
                    state_next = PS_RUN;  // R14
                end
            end
            default: begin
                state_next = PS_RUN;
            end
        endcase
    end

    // Power state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= PS_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Registered state outputs and rearm pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deep_sleep_active <= 1'b0;
            sleep_active      <= 1'b0;
            idle_active       <= 1'b0;
            por_rearm         <= 1'b0;
        end else begin
            deep_sleep_active <= (state_next == PS_DEEP);
            sleep_active      <= (state_next == PS_SLEEP);
            idle_active       <= (state_next == PS_IDLE);
            por_rearm <= (state_reg == PS_DEEP) & bor_event;  // R14
        end
    end

    // ***********************************************************
    // Watchdog enable
    // ***********************************************************
    // Software enable bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_wdt_reg <= 1'b0;
        end else if (wr_en && hit_wdt && pstrb[0]) begin
            soft_wdt_reg <= pwdata[0];
        end
    end

    // Fuse at one overrides software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_enable <= 1'b0;
        end else begin
            watchdog_enable <= watchdog_fuse_enable | soft_wdt_reg;  // R8
        end
    end

    // ***********************************************************
    // APB answer
    // ***********************************************************
    // Registered read data; unmapped addresses raise an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~pready
                       & ~(hit_flags | hit_ds | hit_wdt);
            if (psel && !penable && !pwrite) begin
                if (hit_flags) begin
                    prdata <= {16'h0000, flags_reg};
                end else if (hit_ds) begin
                    prdata <= {16'h0000, ds_view};
                end else if (hit_wdt) begin
                    prdata <= {31'h0000_0000, soft_wdt_reg};
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end

    // ***********************************************************
    // Pin hold
    // ***********************************************************
    pin_hold_latch #(
        .N (N_PINS)
    ) u_hold (
        .pclk    (pclk),
        .presetn (presetn),
        .capture (deep_entry && state_reg == PS_RUN),
        .hold    (hold_reg),
        .dir_in  (port_direction_register),
        .lat_in  (port_latch_register),
        .dir_out (pin_direction),
        .lat_out (pin_level)
    );

    // Read strobe kept for symmetry of decode
    logic unused_rd;
    assign unused_rd = rd_en;
endmodule
`default_nettype wire

// [rcause_sva.sv]
// Port checker for the reset cause and deep-sleep control block
`timescale 1ns/1ns
`default_nettype none
module rcause_sva
    import rcause_pkg::*;
#(
    parameter int N_PINS = PIN_COUNT
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              por_event,
    input wire logic              bor_event,
    input wire logic              power_save_instruction_sleep,
    input wire logic              ds_wake,
    input wire logic              watchdog_fuse_enable,
    input wire logic [N_PINS-1:0] pin_direction,
    input wire logic [N_PINS-1:0] pin_level,
    input wire logic              watchdog_enable,
    input wire logic              deep_sleep_active,
    input wire logic              por_rearm
);
    // ****************************************
    // Properties, all on the bus clock
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Setup cycle of a read, and decode miss
    wire logic rd_setup = psel && !penable && !pwrite;
    wire logic unmapped = !(paddr inside {ADDR_FLAGS, ADDR_DSCTRL, ADDR_WDT});

    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    answer_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    unmapped_zero_a: assert property (psel && !penable && unmapped
        |=> pslverr && pready && ($past(pwrite) || prdata == 32'h0))
        else $error("unmapped access not refused");
    dsctrl_zero_a: assert property (rd_setup && paddr == ADDR_DSCTRL
        |=> prdata[31:16] == 16'h0 && prdata[14:2] == 13'h0)
        else $error("deep control spare bits not zero");
    flags_zero_a: assert property (rd_setup && paddr == ADDR_FLAGS
        |=> (prdata & ~{16'h0, FLAGS_MASK}) == 32'h0)
        else $error("flag spare bits not zero");
    wdt_force_a: assert property (watchdog_fuse_enable |=> watchdog_enable)
        else $error("fuse did not force watchdog");
    bor_rearm_a: assert property (bor_event && deep_sleep_active
        |=> por_rearm)
        else $error("no rearm on deep brown-out");
    deep_stay_a: assert property (bor_event && deep_sleep_active && !ds_wake
        && !por_event |=> deep_sleep_active)
        else $error("brown-out woke deep sleep");
    sleep_flag_a: assert property (power_save_instruction_sleep ##2 rd_setup
        && paddr == ADDR_FLAGS |=> prdata[B_SLEEP])
        else $error("sleep flag not set");
    // Pins frozen in deep sleep unless software touched the bus
    pin_hold_a: assert property (deep_sleep_active && $past(deep_sleep_active)
        && $past(deep_sleep_active, 2) && !$past(psel) && !$past(psel, 2)
        |-> $stable(pin_direction) && $stable(pin_level))
        else $error("pins moved while held");
    // Main scenarios reached
    cover property (pready && pslverr);
    cover property (por_rearm);
    cover property (deep_sleep_active ##1 ds_wake);
endmodule
bind reset_cause_deep_sleep_ctrl rcause_sva #(.N_PINS(N_PINS)) chk (.*);
`default_nettype wire

// [tb.sv]
// Self-checking bench for the reset cause and deep-sleep block
`timescale 1ns/1ns
`default_nettype none
module tb
    import rcause_pkg::*;
;
    // ****************************************
    // Stimulus signals and design instance
    // ****************************************
    logic                 pclk    = 1'b0;   // 100 MHz bus clock
    logic                 presetn = 1'b0;   // Held low for 4 cycles
    logic                 psel    = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite  = 1'b0;
    logic [11:0]          paddr   = 12'h000;
    logic [31:0]          pwdata  = 32'h0;
    logic [3:0]           strb    = 4'h3;    // Byte lanes of a write
    logic [10:0]          ev      = 11'h000; // Event strobes, see pulse
    logic                 fuse    = 1'b0;    // Watchdog fuse level
    logic                 bor_en  = 1'b1;    // Deep brown-out detect on
    logic [PIN_COUNT-1:0] dir_r   = 24'h000000;
    logic [PIN_COUNT-1:0] lat_r   = 24'h000000;
    logic [PIN_COUNT-1:0] pin_dir, pin_lvl;
    logic [31:0]          prdata, rd;
    logic                 pready, pslverr, er, wdt_en, deep_act;
    logic                 slp_act, idl_act, rearm;
    int                   n_errors = 0, num_checks = 0, cycles = 0;

    reset_cause_deep_sleep_ctrl uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .por_event(ev[0]), .bor_event(ev[1]), .ext_reset_event(ev[2]),
        .sw_reset_event(ev[3]), .wdt_timeout_event(ev[4]),
        .trap_conflict_event(ev[5]), .illegal_op_event(ev[6]),
        .config_mismatch_event(ev[7]), .power_save_instruction_sleep(ev[8]),
        .power_save_instruction_idle(ev[9]), .ds_wake(ev[10]), .ds_bor_enable(bor_en),
        .watchdog_fuse_enable(fuse), .port_direction_register(dir_r),
        .port_latch_register(lat_r), .pin_direction(pin_dir),
        .pin_level(pin_lvl), .watchdog_enable(wdt_en),
        .deep_sleep_active(deep_act), .sleep_active(slp_act),
        .idle_active(idl_act), .por_rearm(rearm)
    );

    // Free-running clock and hang guard
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; hw names an event strobe raised at the access edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input int hw);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        if (hw >= 0) ev[hw] <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (hw >= 0) ev[hw] <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, -1);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                          input string nm);
        apb(1'b0, a, 32'h0, -1);
        check(nm, rd, exp);
    endtask

    // One-cycle strobe; returns once its effect has landed
    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
        #1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_events();
        int          bits [7] = '{15, 14, 9, 7, 6, 4, 1};
        int          idx [7]  = '{5, 6, 7, 2, 3, 4, 1};
        logic [31:0] exp;
        rd_chk(ADDR_FLAGS, 32'h3, "flags rst");
        rd_chk(ADDR_DSCTRL, 32'h0, "dsctrl rst");
        rd_chk(12'h00c, 32'h0, "unmapped");
        check("slverr", er, 1'b1);
        wr(ADDR_FLAGS, 32'h0);
        exp = 32'h0;
        rd_chk(ADDR_FLAGS, exp, "flags clr");
        for (int i = 0; i < 7; i++) begin
            pulse(idx[i]);
            exp[bits[i]] = 1'b1;
            rd_chk(ADDR_FLAGS, exp, "flag set");
        end
        pulse(8);
        check("sleep", slp_act, 1'b1);
        check("no deep", deep_act, 1'b0);
        exp[3] = 1'b1;
        exp[4] = 1'b0;
        rd_chk(ADDR_FLAGS, exp, "sleep flag");
        pulse(10);
        pulse(9);
        check("idle", idl_act, 1'b1);
        exp[2] = 1'b1;
        rd_chk(ADDR_FLAGS, exp, "idle flag");
        pulse(10);
        wr(ADDR_FLAGS, 32'hffff);
        rd_chk(ADDR_FLAGS, {16'h0, FLAGS_MASK}, "sw set");
        rd_chk(ADDR_DSCTRL, 32'h0, "no reset");
        // Low lane only: the upper flag byte must survive
        strb <= 4'h1;
        wr(ADDR_FLAGS, 32'h0);
        strb <= 4'h3;
        rd_chk(ADDR_FLAGS, 32'hc600, "lane clr");
        apb(1'b1, ADDR_FLAGS, 32'h0, 2);
        rd_chk(ADDR_FLAGS, 32'h0080, "hw wins");
        $display("flag test done");
    endtask

    task automatic test_deep();
        @(posedge pclk);
        dir_r <= 24'h0f0f0f;
        lat_r <= 24'h123456;
        wr(ADDR_DSCTRL, 32'h8000);
        pulse(8);
        check("deep on", deep_act, 1'b1);
        dir_r <= 24'hf0f0f0;
        lat_r <= 24'hedcba9;
        repeat (3) @(posedge pclk);
        #1;
        check("dir hold", pin_dir, 24'h0f0f0f);
        check("lvl hold", pin_lvl, 24'h123456);
        pulse(1);
        check("rearm", rearm, 1'b1);
        check("no wake", deep_act, 1'b1);
        rd_chk(ADDR_DSCTRL, 32'h8003, "ds status");
        apb(1'b0, ADDR_FLAGS, 32'h0, -1);
        check("deep flag", rd[B_DEEP], 1'b1);
        pulse(0);
        rd_chk(ADDR_DSCTRL, 32'h8003, "ds keep");
        pulse(10);
        wr(ADDR_DSCTRL, 32'h7ffd);
        rd_chk(ADDR_DSCTRL, 32'h0001, "ds spare");
        check("still held", pin_lvl, 24'h123456);
        wr(ADDR_DSCTRL, 32'h0);
        repeat (2) @(posedge pclk);
        #1;
        check("dir free", pin_dir, 24'hf0f0f0);
        check("lvl free", pin_lvl, 24'hedcba9);
        wr(ADDR_DSCTRL, 32'h8000);
        pulse(0);
        rd_chk(ADDR_DSCTRL, 32'h0, "ds por");
        rd_chk(ADDR_FLAGS, 32'h3, "flags por");
        $display("deep test done");
    endtask

    task automatic test_wdt();
        @(posedge pclk);
        fuse <= 1'b1;
        wr(ADDR_WDT, 32'h0);
        check("fuse on", wdt_en, 1'b1);
        fuse <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        check("soft off", wdt_en, 1'b0);
        wr(ADDR_WDT, 32'h1);
        repeat (2) @(posedge pclk);
        #1;
        check("soft on", wdt_en, 1'b1);
        rd_chk(ADDR_WDT, 32'h1, "soft rd");
        $display("watchdog test done");
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        test_events();
        test_deep();
        test_wdt();
        tally_and_finish();
    end
endmodule
`default_nettype wire
